// ### hdl/flash_map_pkg.sv
// Package for the flash protect and memory map control block.
// Assumes a single clock domain and byte-wide registers placed in 32-bit AXI4-Lite words.
package flash_map_pkg;
  // ---------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_PROTECT   = 12'h0fb7;  // Command on write, status on read.
  localparam logic [11:0] IDX_CTRL_ONE  = 12'h0fd0;
  localparam logic [11:0] IDX_COMMIT    = 12'h0fd1;  // Commit on write, shadow monitor on read.
  localparam logic [11:0] IDX_PORT_GATE = 12'h0fd3;
  localparam logic [11:0] IDX_SYS_THREE = 12'h0fe0;
  localparam logic [11:0] IDX_SYS_COMMIT= 12'h0fe1;
  localparam logic [11:0] IDX_MAP_STAT  = 12'h0fe2;
  // ---------------------------------------------------------------
  // Codes and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] UNLOCK_FIRST   = 8'h6f;
  localparam logic [7:0] UNLOCK_SECOND  = 8'h75;
  localparam logic [7:0] COMMIT_FLASH   = 8'hd5;
  localparam logic [7:0] COMMIT_SYSTEM  = 8'hd4;
  localparam logic [2:0] CMD_ENABLE     = 3'b101;
  localparam logic [2:0] CMD_DISABLE    = 3'b010;
  localparam logic [1:0] AREA_DEFAULT   = 2'b00;
  localparam logic [1:0] AREA_MIRROR    = 2'b10;
  localparam int         UNLOCK_BIT     = 6;
  localparam int         UNDEF_BIT      = 5;
  localparam int         CMD_LSB        = 5;
  localparam int         BOOT_BIT       = 4;
  localparam int         AREA_LSB       = 2;
  localparam int         SERCLK_BIT     = 1;
  localparam int         GENERAL_BIT    = 0;
  localparam int         RAM_BIT        = 0;
  localparam logic [7:0] CTRL_ONE_RESET = 8'h40;
  localparam logic [1:0] AXI_OKAY       = 2'b00;
  localparam logic [1:0] AXI_SLVERR     = 2'b10;
endpackage

// ### hdl/reg_bus_if.sv
// Byte-wide register access strobes passed from the bus slave to the register core.
// Assumes one access per cycle, single clock domain.
interface reg_bus_if;
  logic        wr;
  logic        rd;
  logic [11:0] idx;
  logic [7:0]  wdata;
  logic [7:0]  rdata;
  logic        hit;
  modport slave  (output wr, rd, idx, wdata, input rdata, hit);
  modport core   (input wr, rd, idx, wdata, output rdata, hit);
endinterface

// ### hdl/axil_byte_slave.sv
// AXI4-Lite slave that turns word accesses into byte register strobes.
// Assumes registers sit in the low byte lane; writes need wstrb[0].
module axil_byte_slave
  import flash_map_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  reg_bus_if.slave         rb
);
  logic        aw_held_reg;
  logic        w_held_reg;
  logic [11:0] waddr_reg;
  logic [7:0]  wbyte_reg;
  logic        wlane_reg;
  wire         wr_go = aw_held_reg && w_held_reg && !bvalid;
  wire         rd_go = arvalid && !rvalid && !wr_go;

  // Address and data are taken independently; the write fires once both are held.
  assign awready  = !aw_held_reg;
  assign wready   = !w_held_reg;
  assign arready  = rd_go;
  assign rb.wr    = wr_go && wlane_reg;
  assign rb.rd    = rd_go;
  assign rb.idx   = wr_go ? waddr_reg : araddr[13:2];
  assign rb.wdata = wbyte_reg;

  // --------------------------------------------------------------
  // Channel state
  // --------------------------------------------------------------
  // Writes win a same-cycle tie so that the read sees written state next time.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      aw_held_reg <= 1'b0;
      w_held_reg  <= 1'b0;
      waddr_reg   <= '0;
      wbyte_reg   <= '0;
      wlane_reg   <= 1'b0;
      bvalid      <= 1'b0;
      bresp       <= AXI_OKAY;
      rvalid      <= 1'b0;
      rdata       <= '0;
      rresp       <= AXI_OKAY;
    end
    else
    begin
      if (awvalid && !aw_held_reg)
      begin
        aw_held_reg <= 1'b1;
        waddr_reg   <= awaddr[13:2];
      end
      if (wvalid && !w_held_reg)
      begin
        w_held_reg <= 1'b1;
        wbyte_reg  <= wdata[7:0];
        wlane_reg  <= wstrb[0];
      end
      if (wr_go)
      begin
        aw_held_reg <= 1'b0;
        w_held_reg  <= 1'b0;
        bvalid      <= 1'b1;
        bresp       <= rb.hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (bvalid && bready)
        bvalid <= 1'b0;
      if (rd_go)
      begin
        rvalid <= 1'b1;
        rdata  <= {24'h00_0000, rb.rdata};
        rresp  <= rb.hit ? AXI_OKAY : AXI_SLVERR;
      end
      else if (rvalid && rready)
        rvalid <= 1'b0;
    end
  end
endmodule // axil_byte_slave

// ### hdl/flash_protect_and_map_ctrl.sv
// Flash protect-cancel, port input gating, command enable and memory map control.
// Assumes the CPU reports its fetch region and serial programming mode as synchronous levels.
// Behaviour
// - Writes 0x6F then 0x75 to the protect command register enter protect cancel mode.
// - Any other value written to the protect command register returns to normal mode.
// - Status bit 6 reads 1 in protect cancel mode, else 0; read-only.
// - Status bit 5 reads undefined; other unused status bits read zero.
// - In serial mode the serial-clock gate bit enables that pin input alone.
// - In serial mode the general gate bit enables all other port inputs.
// - In CPU mode the gating register ignores writes, reads zero, inputs enabled.
// - Command field 101 plus commit 0xD5 enables flash commands and toggle.
// - Command field 010 plus commit disables flash commands and toggle.
// - While disabled, flash command writes, and toggle reads with no sequence busy, do not reach the array.
// - Reset sets the command field to 010, commands disabled.
// - Disabling rejects later commands but keeps a sequence already running.
// - Area field 10 with commit mirrors code 0x8000-0xFFFF into data space.
// - Area field 00 with commit restores default flash mapping.
// - Memory transfer flash accesses act on data-space addresses only.
// - In CPU mode RAM bit plus 0xD4 commit maps RAM into code space.
// - In serial mode RAM is always mapped into code space.
// - In CPU mode boot bit plus commit maps boot ROM over 0x1000-0x17FF.
// - In CPU mode clearing boot bit plus 0xD5 commit hides boot ROM.
// - In serial mode boot ROM maps data 0x1000-0x17FF, code to 0x1FFF; bit reads 1.
// - Flash control values only take effect in the shadow on commit 0xD5.
// - A monitor register shows the shadow; its enable flag is 1 only for 101.
// - Protect cancel mode also ends on reset or a fetch from flash.
// - Protect command writes count only when code is running from RAM.
//
// Design decision made here: the AXI4-Lite interface to the registers.
module flash_protect_and_map_ctrl
  import flash_map_pkg::*;
(
  input  wire logic        ref_clk,
  input  wire logic        rst,
  input  wire logic [15:0] awaddr,
  input  wire logic        awvalid,
  output logic             awready,
  input  wire logic [31:0] wdata,
  input  wire logic [3:0]  wstrb,
  input  wire logic        wvalid,
  output logic             wready,
  output logic [1:0]       bresp,
  output logic             bvalid,
  input  wire logic        bready,
  input  wire logic [15:0] araddr,
  input  wire logic        arvalid,
  output logic             arready,
  output logic [31:0]      rdata,
  output logic [1:0]       rresp,
  output logic             rvalid,
  input  wire logic        rready,
  input  wire logic        serial_mode,
  input  wire logic        fetch_in_ram,
  input  wire logic        fetch_in_flash,
  input  wire logic        undef_bit_src,
  input  wire logic        flash_wr_req,
  input  wire logic        flash_toggle_req,
  input  wire logic        data_space_req,
  input  wire logic        flash_seq_busy,
  output logic             flash_wr_pass,
  output logic             flash_toggle_pass,
  output logic             unlock_active,
  output logic             serclk_input_en,
  output logic             general_input_en,
  output logic             cmd_enabled,
  output logic             data_mirror_en,
  output logic             ram_in_code,
  output logic             boot_in_data,
  output logic             boot_in_code_wide
);
  import flash_map_pkg::*;

  reg_bus_if rb ();

  // --------------------------------------------------------------
  // Bus slave
  // --------------------------------------------------------------
  axil_byte_slave u_slave (
    .ref_clk (ref_clk),
    .rst     (rst),
    .awaddr  (awaddr),
    .awvalid (awvalid),
    .awready (awready),
    .wdata   (wdata),
    .wstrb   (wstrb),
    .wvalid  (wvalid),
    .wready  (wready),
    .bresp   (bresp),
    .bvalid  (bvalid),
    .bready  (bready),
    .araddr  (araddr),
    .arvalid (arvalid),
    .arready (arready),
    .rdata   (rdata),
    .rresp   (rresp),
    .rvalid  (rvalid),
    .rready  (rready),
    .rb      (rb)
  );

  logic       first_seen_reg;
  logic       unlock_reg;
  logic [7:0] ctrl_one_reg;
  logic [7:0] shadow_reg;
  logic [1:0] port_gate_reg;
  logic       ram_bit_reg;
  logic       ram_map_reg;

  // --------------------------------------------------------------
  // Register decode
  // --------------------------------------------------------------
  wire wr_protect = rb.wr && rb.idx == IDX_PROTECT && fetch_in_ram;
  wire wr_ctrl    = rb.wr && rb.idx == IDX_CTRL_ONE;
  wire wr_commit  = rb.wr && rb.idx == IDX_COMMIT && rb.wdata == COMMIT_FLASH;
  wire wr_gate    = rb.wr && rb.idx == IDX_PORT_GATE && serial_mode;
  wire wr_sys3    = rb.wr && rb.idx == IDX_SYS_THREE;
  wire wr_sys_cmt = rb.wr && rb.idx == IDX_SYS_COMMIT && rb.wdata == COMMIT_SYSTEM;

  wire [2:0] shadow_cmd  = shadow_reg[CMD_LSB+2:CMD_LSB];
  wire [1:0] shadow_area = shadow_reg[AREA_LSB+1:AREA_LSB];
  wire       cmd_on      = shadow_cmd == CMD_ENABLE;
  // Serial mode forces the boot bit to read 1 and the mapped state to show.
  wire       boot_eff    = serial_mode | shadow_reg[BOOT_BIT];

  // Status: bit 6 mode, bit 5 loose, rest zero.
  wire [7:0] status_rd;
  assign status_rd = {1'b0, unlock_reg, undef_bit_src, 5'b0_0000};
  wire [7:0] ctrl_rd;
  assign ctrl_rd = {ctrl_one_reg[7:5], ctrl_one_reg[BOOT_BIT] | serial_mode,
                    ctrl_one_reg[3:0]};
  wire [7:0] monitor_rd;
  assign monitor_rd = {2'b00, cmd_on, boot_eff, shadow_area, 2'b00};
  wire [7:0] gate_rd;
  assign gate_rd = serial_mode ? {6'b00_0000, port_gate_reg} : 8'h00;

  // Read multiplexer; unmapped indices answer with an error.
  assign rb.hit = rb.idx == IDX_PROTECT || rb.idx == IDX_CTRL_ONE ||
                  rb.idx == IDX_COMMIT || rb.idx == IDX_PORT_GATE ||
                  rb.idx == IDX_SYS_THREE || rb.idx == IDX_SYS_COMMIT ||
                  rb.idx == IDX_MAP_STAT;
  assign rb.rdata = rb.idx == IDX_PROTECT   ? status_rd :
                    rb.idx == IDX_CTRL_ONE  ? ctrl_rd :
                    rb.idx == IDX_COMMIT    ? monitor_rd :
                    rb.idx == IDX_PORT_GATE ? gate_rd :
                    rb.idx == IDX_SYS_THREE ? {7'h00, ram_bit_reg} :
                    rb.idx == IDX_MAP_STAT  ? {7'h00, ram_map_reg} : 8'h00;

  // --------------------------------------------------------------
  // Protect cancel detector
  // --------------------------------------------------------------
  // A flash fetch ends the mode at once so flash code never runs unlocked.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      first_seen_reg <= 1'b0;
      unlock_reg     <= 1'b0;
    end
    else if (fetch_in_flash)
    begin
      first_seen_reg <= 1'b0;
      unlock_reg     <= 1'b0;
    end
    else if (wr_protect)
    begin
      first_seen_reg <= rb.wdata == UNLOCK_FIRST;
      unlock_reg     <= first_seen_reg && rb.wdata == UNLOCK_SECOND;
    end
  end

  // --------------------------------------------------------------
  // Flash control and shadow
  // --------------------------------------------------------------
  // Writes land in the holding register; only the commit copies them live.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      ctrl_one_reg <= CTRL_ONE_RESET;
      shadow_reg   <= CTRL_ONE_RESET;
    end
    else
    begin
      if (wr_ctrl)
        ctrl_one_reg <= rb.wdata;
      if (wr_commit)
        shadow_reg <= ctrl_one_reg;
    end
  end

  // --------------------------------------------------------------
  // Port gating and RAM map
  // --------------------------------------------------------------
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      port_gate_reg <= 2'b00;
      ram_bit_reg   <= 1'b0;
      ram_map_reg   <= 1'b0;
    end
    else
    begin
      if (wr_gate)
        port_gate_reg <= rb.wdata[1:0];
      if (wr_sys3)
        ram_bit_reg <= rb.wdata[RAM_BIT];
      if (wr_sys_cmt)
        ram_map_reg <= ram_bit_reg;
    end
  end

  // --------------------------------------------------------------
  // Registered outputs
  // --------------------------------------------------------------
  // Command gating uses the live shadow; a sequence already running keeps its toggle
  // pass (the write pass still needs the enable) so disabling never cuts a started sequence short.
  always_ff @(posedge ref_clk)
  begin
    if (rst)
    begin
      flash_wr_pass     <= 1'b0;
      flash_toggle_pass <= 1'b0;
      unlock_active     <= 1'b0;
      serclk_input_en   <= 1'b1;
      general_input_en  <= 1'b1;
      cmd_enabled       <= 1'b0;
      data_mirror_en    <= 1'b0;
      ram_in_code       <= 1'b0;
      boot_in_data      <= 1'b0;
      boot_in_code_wide <= 1'b0;
    end
    else
    begin
      flash_wr_pass     <= flash_wr_req && data_space_req && cmd_on;
      flash_toggle_pass <= flash_toggle_req && data_space_req &&
                           (cmd_on || flash_seq_busy);
      unlock_active     <= unlock_reg;
      serclk_input_en   <= !serial_mode || port_gate_reg[SERCLK_BIT];
      general_input_en  <= !serial_mode || port_gate_reg[GENERAL_BIT];
      cmd_enabled       <= cmd_on;
      data_mirror_en    <= shadow_area == AREA_MIRROR;
      ram_in_code       <= serial_mode || ram_map_reg;
      boot_in_data      <= boot_eff;
      boot_in_code_wide <= serial_mode;
    end
  end
endmodule // flash_protect_and_map_ctrl

// ### tb/flash_map_properties.sv
// Concurrent checks on the flash protect and memory map control block.
// Assumes it is bound to the top module and sees only that module's ports.
module flash_map_properties (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic serial_mode,
  input wire logic fetch_in_flash,
  input wire logic flash_wr_req,
  input wire logic data_space_req,
  input wire logic flash_seq_busy,
  input wire logic bready,
  input wire logic rready,
  input wire logic bvalid,
  input wire logic rvalid,
  input wire logic flash_wr_pass,
  input wire logic flash_toggle_pass,
  input wire logic unlock_active,
  input wire logic serclk_input_en,
  input wire logic general_input_en,
  input wire logic cmd_enabled,
  input wire logic data_mirror_en,
  input wire logic ram_in_code,
  input wire logic boot_in_data,
  input wire logic boot_in_code_wide
);
  // ---------------------------------------------------------------
  // Properties
  // ---------------------------------------------------------------
  // Outputs are one flop behind their cause, unlock_active two behind fetch_in_flash, so each check waits that out.
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (rst);
  reset_values_a: assert property (disable iff (1'b0) rst |=>
    !unlock_active && !cmd_enabled && !data_mirror_en) else $error("reset outputs wrong");
  flash_exit_a: assert property (fetch_in_flash [*2] |=> !unlock_active)
    else $error("unlock kept during flash fetch");
  // Both outputs come from the same live shadow through one flop, so they line up.
  cmd_block_a: assert property (!cmd_enabled |-> !flash_wr_pass)
    else $error("flash write passed while disabled");
  toggle_block_a: assert property (!flash_seq_busy ##1 !cmd_enabled
    |-> !flash_toggle_pass) else $error("toggle passed while disabled and idle");
  data_space_a: assert property ((!data_space_req) [*2] |=> !flash_wr_pass)
    else $error("flash write passed outside data space");
  cpu_gates_a: assert property ((!serial_mode) [*2] |=>
    serclk_input_en && general_input_en) else $error("port input gated in cpu mode");
  serial_ram_a: assert property (serial_mode [*2] |=> ram_in_code)
    else $error("ram not in code space in serial mode");
  serial_boot_a: assert property (serial_mode [*2] |=> boot_in_data && boot_in_code_wide)
    else $error("boot rom not mapped in serial mode");
  cpu_narrow_a: assert property ((!serial_mode) [*2] |=> !boot_in_code_wide)
    else $error("wide boot code window in cpu mode");
  bresp_hold_a: assert property (bvalid && !bready |=> bvalid)
    else $error("write response dropped early");
  rresp_hold_a: assert property (rvalid && !rready |=> rvalid)
    else $error("read response dropped early");
endmodule // flash_map_properties

// ### tb/testbench.sv
// Self-checking bench for the flash protect and memory map control block.
// Assumes AXI4-Lite registers one byte per word and registered level outputs.
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  import flash_map_pkg::*;
  // ---------------------------------------------------------------
  // Signals and model state
  // ---------------------------------------------------------------
  localparam logic [11:0] IDX_NONE = 12'h0100;  // Unmapped register index.
  logic        ref_clk, rst, awvalid, wvalid, bready, arvalid, rready, serial_mode;
  logic        fetch_in_ram, fetch_in_flash, undef_bit_src, flash_wr_req, flash_toggle_req;
  logic        data_space_req, flash_seq_busy, awready, wready, bvalid, arready, rvalid;
  logic        flash_wr_pass, flash_toggle_pass, unlock_active, serclk_input_en;
  logic        general_input_en, cmd_enabled, data_mirror_en, ram_in_code, boot_in_data;
  logic        boot_in_code_wide;
  logic [15:0] awaddr, araddr;
  logic [31:0] wdata, rdata, rd_v;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, resp;
  logic [7:0]  ctrl_m, sh_m, prev_m, gate_m, v;
  logic [7:0]  tbl [4] = '{8'ha0, 8'h48, 8'h50, 8'h40};
  int          err_total, checks, unl_m, r3_m, ram_m, r;

  flash_protect_and_map_ctrl dut_u (.ref_clk, .rst, .awaddr, .awvalid, .awready, .wdata,
    .wstrb, .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready, .rdata,
    .rresp, .rvalid, .rready, .serial_mode, .fetch_in_ram, .fetch_in_flash, .undef_bit_src,
    .flash_wr_req, .flash_toggle_req, .data_space_req, .flash_seq_busy, .flash_wr_pass,
    .flash_toggle_pass, .unlock_active, .serclk_input_en, .general_input_en, .cmd_enabled,
    .data_mirror_en, .ram_in_code, .boot_in_data, .boot_in_code_wide);

  // Free-running 200 MHz clock.
  initial
  begin
    ref_clk = 1'b0;
    forever #2.5 ref_clk = ~ref_clk;
  end
  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic stop_test();
    $display("checks %0d err_total %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks++;
    if (g !== e)
    begin
      err_total++;
      $display("[FAIL] %s expected %h seen %h", n, e, g);
    end
  endtask

  // One bus transfer; ready is sampled at the falling edge, where it already
  // holds the value that the next rising edge will see, which avoids a race.
  task automatic xfer(input bit we, input logic [11:0] i, input logic [7:0] d);
    int n;
    bit a_t, w_t, d_t;
    @(posedge ref_clk);
    awaddr <= {2'b00, i, 2'b00};
    araddr <= {2'b00, i, 2'b00};
    wdata <= {24'h00_0000, d};
    {awvalid, wvalid, bready} <= {3{we}};
    {arvalid, rready} <= {2{!we}};
    for (n = 0; n < 40; n++)
    begin
      @(negedge ref_clk);
      a_t = we ? awvalid && awready : arvalid && arready;
      w_t = wvalid && wready;
      d_t = we ? bvalid : rvalid;
      resp = we ? bresp : rresp;
      rd_v = rdata;
      @(posedge ref_clk);
      awvalid <= awvalid & ~a_t;
      arvalid <= arvalid & ~a_t;
      wvalid <= wvalid & ~w_t;
      bready <= bready & ~d_t;
      rready <= rready & ~d_t;
      if (d_t) break;
    end
    chk("resp", {30'h0, i == IDX_NONE ? AXI_SLVERR : AXI_OKAY}, {30'h0, resp});
    if (n == 40)
    begin
      err_total++;
      stop_test();
    end
  endtask

  // Register write followed by the model's view of its effect.
  task automatic wr(input logic [11:0] i, input logic [7:0] d);
    xfer(1'b1, i, d);
    case (i)
      IDX_PROTECT: if (fetch_in_ram)
      begin
        unl_m = (d == UNLOCK_SECOND && prev_m == UNLOCK_FIRST);
        prev_m = d;
      end
      IDX_CTRL_ONE: ctrl_m = d;
      IDX_COMMIT: if (d == COMMIT_FLASH) sh_m = ctrl_m;
      IDX_SYS_THREE: r3_m = d[RAM_BIT];
      IDX_SYS_COMMIT: if (d == COMMIT_SYSTEM) ram_m = r3_m;
      IDX_PORT_GATE: if (serial_mode) gate_m = d;
      default: ;
    endcase
  endtask

  task automatic rd(input logic [11:0] i, input logic [31:0] e, input logic [31:0] m);
    xfer(1'b0, i, 8'h00);
    chk("rdata", e, rd_v & m);
  endtask

  // Random flash requests, then every output against the model once settled.
  task automatic outs();
    @(posedge ref_clk);
    {flash_wr_req, flash_toggle_req, data_space_req, flash_seq_busy} <= 4'($urandom);
    repeat (3) @(posedge ref_clk);
    @(negedge ref_clk);
    chk("unlock", unl_m, unlock_active);
    chk("cmd", sh_m[7:5] == CMD_ENABLE, cmd_enabled);
    chk("mirror", sh_m[3:2] == AREA_MIRROR, data_mirror_en);
    chk("boot", serial_mode | sh_m[BOOT_BIT], boot_in_data);
    chk("wide", serial_mode, boot_in_code_wide);
    chk("ram", serial_mode || ram_m, ram_in_code);
    chk("serclk", serial_mode ? gate_m[SERCLK_BIT] : 1'b1, serclk_input_en);
    chk("general", serial_mode ? gate_m[GENERAL_BIT] : 1'b1, general_input_en);
    chk("wrpass", flash_wr_req & data_space_req & (sh_m[7:5] == CMD_ENABLE), flash_wr_pass);
    chk("toggle", flash_toggle_req & data_space_req &
      (flash_seq_busy | (sh_m[7:5] == CMD_ENABLE)), flash_toggle_pass);
  endtask
  // ---------------------------------------------------------------
  // Stimulus
  // ---------------------------------------------------------------
  initial
  begin
    {awvalid, wvalid, bready, arvalid, rready, serial_mode, fetch_in_flash} = '0;
    {flash_wr_req, flash_toggle_req, data_space_req, flash_seq_busy, unl_m, r3_m, ram_m} = '0;
    {awaddr, araddr, wdata, gate_m, prev_m, err_total, checks} = '0;
    {rst, fetch_in_ram} = '1;
    wstrb = 4'h1;
    ctrl_m = CTRL_ONE_RESET;
    sh_m = CTRL_ONE_RESET;
    undef_bit_src = 1'($urandom(32'hbae03f2d));
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    rd(IDX_CTRL_ONE, 32'(CTRL_ONE_RESET), '1);
    rd(IDX_PORT_GATE, 32'h0000_0000, '1);
    outs();
    // Random protect traffic, with the status read after each decided write.
    for (int k = 0; k < 24; k++)
    begin
      r = $urandom_range(3);
      v = r == 0 ? UNLOCK_FIRST : r == 1 ? UNLOCK_SECOND : 8'($urandom);
      wr(IDX_PROTECT, v);
      outs();
      rd(IDX_PROTECT, unl_m << UNLOCK_BIT, 32'hffff_ffdf);
    end
    wr(IDX_PROTECT, UNLOCK_FIRST);
    wr(IDX_PROTECT, 8'h12);
    wr(IDX_PROTECT, UNLOCK_SECOND);
    outs();
    // A reset in mid-run must drop the mode; the model is otherwise at reset values.
    wr(IDX_PROTECT, UNLOCK_FIRST);
    wr(IDX_PROTECT, UNLOCK_SECOND);
    rst <= 1'b1;
    repeat (2) @(posedge ref_clk);
    rst <= 1'b0;
    {unl_m, prev_m} = '0;
    outs();
    wr(IDX_PROTECT, UNLOCK_FIRST);
    wr(IDX_PROTECT, UNLOCK_SECOND);
    @(posedge ref_clk);
    fetch_in_flash <= 1'b1;
    repeat (2) @(posedge ref_clk);
    fetch_in_flash <= 1'b0;
    {unl_m, prev_m} = '0;
    outs();
    fetch_in_ram <= 1'b0;
    wr(IDX_PROTECT, UNLOCK_FIRST);
    wr(IDX_PROTECT, UNLOCK_SECOND);
    outs();
    fetch_in_ram <= 1'b1;
    // Control values staged, then committed: enable, mirror, boot, default.
    for (int k = 0; k < 4; k++)
    begin
      wr(IDX_CTRL_ONE, tbl[k]);
      outs();
      flash_seq_busy <= 1'b0;
      wr(IDX_COMMIT, COMMIT_FLASH);
      outs();
      rd(IDX_COMMIT, {26'h0, sh_m[7:5] == CMD_ENABLE, sh_m[BOOT_BIT], sh_m[3:2], 2'b00}, '1);
    end
    wr(IDX_SYS_THREE, 8'h01);
    outs();
    wr(IDX_SYS_COMMIT, COMMIT_SYSTEM);
    rd(IDX_MAP_STAT, 32'h0000_0001, 32'h0000_0001);
    outs();
    wr(IDX_SYS_THREE, 8'h00);
    wr(IDX_SYS_COMMIT, COMMIT_SYSTEM);
    outs();
    // Serial programming mode: gates, forced RAM and boot mapping.
    serial_mode <= 1'b1;
    for (int k = 1; k < 3; k++)
    begin
      wr(IDX_PORT_GATE, 8'(k));
      outs();
      rd(IDX_PORT_GATE, k, '1);
    end
    rd(IDX_COMMIT, 32'h0000_0010, 32'h0000_0010);
    serial_mode <= 1'b0;
    wr(IDX_PORT_GATE, 8'h03);
    outs();
    rd(IDX_PORT_GATE, 32'h0000_0000, '1);
    wr(IDX_NONE, 8'h55);
    rd(IDX_NONE, 32'h0000_0000, '1);
    stop_test();
  end
endmodule // testbench

bind flash_protect_and_map_ctrl flash_map_properties chk_u (.ref_clk, .rst, .serial_mode,
  .fetch_in_flash, .flash_wr_req, .data_space_req, .flash_seq_busy, .bready, .rready, .bvalid,
  .rvalid, .flash_wr_pass, .flash_toggle_pass, .unlock_active, .serclk_input_en,
  .general_input_en, .cmd_enabled, .data_mirror_en, .ram_in_code, .boot_in_data,
  .boot_in_code_wide);
